/* src/spg_pkg.sv */
package spg_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [3:0] OFF_SLEEP_CTRL = 4'h0;
  localparam logic [3:0] OFF_CORE_MISC  = 4'h4;
  localparam logic [3:0] OFF_PWR_SECOND = 4'h8;
  localparam logic [3:0] OFF_PWR_FIRST  = 4'hC;
  localparam logic [3:0] OFF_STATUS     = 4'h0;  // Read-only status, placed at 0x10.
  localparam logic [4:0] OFF_STATUS_FULL = 5'h10;

  // Field positions.
  localparam int SLEEP_ARM_BIT      = 0;
  localparam int SLEEP_MODE_LSB     = 1;
  localparam int BO_UNLOCK_BIT      = 5;
  localparam int BO_OFF_BIT         = 6;
  localparam int GATE_TIMER3_BIT    = 0;
  localparam int GATE_ADC_BIT       = 0;
  localparam int GATE_SERIAL0_BIT   = 1;
  localparam int GATE_SPI_BIT       = 2;
  localparam int GATE_TIMER1_BIT    = 3;
  localparam int GATE_SERIAL1_BIT   = 4;
  localparam int GATE_TIMER0_BIT    = 5;
  localparam int GATE_TIMER2_BIT    = 6;
  localparam int GATE_TWO_WIRE_BIT  = 7;

  // Reset values.
  localparam logic [7:0] RST_SLEEP_CTRL = 8'h00;
  localparam logic [7:0] RST_CORE_MISC  = 8'h00;
  localparam logic [7:0] RST_PWR_SECOND = 8'h00;
  localparam logic [7:0] RST_PWR_FIRST  = 8'h00;

  // Timing counts.
  localparam logic [2:0] UNLOCK_WINDOW_CYC = 3'h4;
  localparam logic [1:0] BO_OFF_LIFE_CYC   = 2'h3;
  localparam logic [2:0] STANDBY_WAKE_CYC  = 3'h6;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sleep mode encodings.
  typedef enum logic [2:0] {
    MODE_IDLE      = 3'h0,
    MODE_ADC_NR    = 3'h1,
    MODE_PWR_DOWN  = 3'h2,
    MODE_PWR_SAVE  = 3'h3,
    MODE_RSVD_A    = 3'h4,
    MODE_RSVD_B    = 3'h5,
    MODE_STANDBY   = 3'h6,
    MODE_EXT_STBY  = 3'h7
  } spg_mode_t;

  typedef enum {
    ST_RUN,
    ST_SLEEP,
    ST_WAKE
  } spg_state_t;

endpackage : spg_pkg

/* src/spg_ctrl.sv */
// Functional notes
// [R1] Mode field bits 3:1 selects six sleep modes.
// [R2] Sleep instruction sleeps only with arm bit set.
// [R3] Software arms just before sleep, clears after.
// [R4] Standby modes only with external crystal clock.
// [R5] Brown-out off set by two-step timed write.
// [R6] Brown-out off becomes active three cycles later.
// [R7] Brown-out off self-clears three cycles after set; the code clears it six cycles after set.
// [R8] Sleep while active switches brown-out detector off.
// [R9] Unlock bit gates setting of brown-out off.
// [R10] Timer three gated; resumes unchanged when cleared.
// [R11] Two-wire clock gated; software reinitialises it.
// [R12] Timer two gated only in synchronous mode.
// [R13] Timer zero gated; continues from frozen state.
// [R14] Serial port one clock gated; reinitialise after.
// [R15] Timer one gated; continues from frozen state.
// [R16] SPI clock gated; software reinitialises it.
// [R17] Serial port zero clock gated; reinitialise after.
// [R18] ADC gated; software disables ADC first.
// [R19] Gated ADC blocks comparator multiplexer use.
// [R20] System reset restores all registers.
// [R21] Gated peripheral frozen, its registers inaccessible.
// [R22] Ungating restores exact previous module state.
// [R23] Standby modes resume six cycles after wake.
// [R24] Reserved mode encodings never enter sleep.
// [R25] Reserved second-register bits read zero.
`timescale 1ns/1ps
module spg_ctrl (
  input  wire logic        clock,                // System clock, 100 MHz.
  input  wire logic        reset_n,              // Asynchronous active-low reset.
  input  wire logic [31:0] s_axi_awaddr,         // Write address.
  input  wire logic        s_axi_awvalid,        // Write address valid.
  output logic             s_axi_awready,        // Write address ready.
  input  wire logic [31:0] s_axi_wdata,          // Write data.
  input  wire logic [3:0]  s_axi_wstrb,          // Write byte strobes.
  input  wire logic        s_axi_wvalid,         // Write data valid.
  output logic             s_axi_wready,         // Write data ready.
  output logic [1:0]       s_axi_bresp,          // Write response.
  output logic             s_axi_bvalid,         // Write response valid.
  input  wire logic        s_axi_bready,         // Write response ready.
  input  wire logic [31:0] s_axi_araddr,         // Read address.
  input  wire logic        s_axi_arvalid,        // Read address valid.
  output logic             s_axi_arready,        // Read address ready.
  output logic [31:0]      s_axi_rdata,          // Read data.
  output logic [1:0]       s_axi_rresp,          // Read response.
  output logic             s_axi_rvalid,         // Read data valid.
  input  wire logic        s_axi_rready,         // Read data ready.
  input  wire logic        sleep_instr,          // Core executes sleep, one-cycle pulse.
  input  wire logic        wake_event,           // Wake-up condition from wake sources.
  input  wire logic        timer_two_async_select, // Timer two asynchronous mode level.
  output logic             core_halt,            // Core stalled while asleep or waking.
  output logic             sleep_active,         // Device is in a sleep state.
  output logic [2:0]       sleep_mode_out,       // Mode latched at sleep entry.
  output logic             brownout_detector_off, // Brown-out detector disabled in sleep.
  output logic             clk_en_two_wire,      // Clock enable, two-wire interface.
  output logic             clk_en_timer_two,     // Clock enable, timer two.
  output logic             clk_en_timer_zero,    // Clock enable, timer zero.
  output logic             clk_en_serial_one,    // Clock enable, serial port one.
  output logic             clk_en_timer_one,     // Clock enable, timer one.
  output logic             clk_en_spi,           // Clock enable, SPI.
  output logic             clk_en_serial_zero,   // Clock enable, serial port zero.
  output logic             clk_en_adc,           // Clock enable, ADC.
  output logic             clk_en_timer_three,   // Clock enable, timer three.
  output logic             comparator_mux_allow  // Comparator may use ADC input multiplexer.
);

  // Reset release through two flops so every flop sees a clean synchronous deassert.
  logic rst_meta_ff;
  logic rst_sync_ff;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  logic rst_n;
  assign rst_n = rst_sync_ff;

  // Registers.
  logic [7:0] sleep_mode_control_ff;
  logic [7:0] power_reduction_first_ff;
  logic       gate_timer_three_ff;
  logic       brownout_sleep_unlock_ff;
  logic       brownout_sleep_off_ff;
  logic [2:0] unlock_cnt_ff;
  logic [1:0] bo_life_cnt_ff;
  logic [1:0] bo_arm_cnt_ff;

  // Write channel capture: address and data may arrive in either order.
  logic [3:0]  wr_addr_ff;
  logic        wr_addr_ok_ff;
  logic [31:0] wr_data_ff;
  logic [3:0]  wr_strb_ff;
  logic        wr_data_ok_ff;
  logic        wr_bad_ff;

  // Decodes a byte address into a register hit; used by both read and write.
  function automatic logic addr_mapped(input logic [31:0] addr);
    addr_mapped = (addr[31:5] == 27'h0) && (addr[1:0] == 2'h0) &&
                  (!addr[4] || addr[3:0] == spg_pkg::OFF_STATUS);
  endfunction : addr_mapped

  assign s_axi_awready = !wr_addr_ok_ff && !s_axi_bvalid;
  assign s_axi_wready  = !wr_data_ok_ff && !s_axi_bvalid;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_addr_ok_ff <= 1'b0;
      wr_addr_ff    <= 4'h0;
      wr_bad_ff     <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      wr_addr_ok_ff <= 1'b1;
      wr_addr_ff    <= s_axi_awaddr[3:0];
      wr_bad_ff     <= !addr_mapped(s_axi_awaddr) || s_axi_awaddr[4];
    end else if (wr_addr_ok_ff && wr_data_ok_ff) begin
      wr_addr_ok_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_data_ok_ff <= 1'b0;
      wr_data_ff    <= 32'h0;
      wr_strb_ff    <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wr_data_ok_ff <= 1'b1;
      wr_data_ff    <= s_axi_wdata;
      wr_strb_ff    <= s_axi_wstrb;
    end else if (wr_addr_ok_ff && wr_data_ok_ff) begin
      wr_data_ok_ff <= 1'b0;
    end
  end

  // A write commits the cycle after both halves are held; only byte lane 0 carries data.
  logic       wr_go;
  logic [7:0] wbyte;
  assign wr_go = wr_addr_ok_ff && wr_data_ok_ff && !wr_bad_ff && wr_strb_ff[0];
  assign wbyte = wr_data_ff[7:0];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= spg_pkg::RESP_OKAY;
    end else if (wr_addr_ok_ff && wr_data_ok_ff) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_bad_ff ? spg_pkg::RESP_SLVERR : spg_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Sleep control; bits 7:4 stay zero.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sleep_mode_control_ff <= spg_pkg::RST_SLEEP_CTRL;               // [R20]
    end else if (wr_go && wr_addr_ff == spg_pkg::OFF_SLEEP_CTRL) begin
      sleep_mode_control_ff <= {4'h0, wbyte[3:0]};                    // [R1]
    end
  end

  // Power reduction registers; set bits gate the peripheral clocks.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      power_reduction_first_ff <= spg_pkg::RST_PWR_FIRST;             // [R20]
      gate_timer_three_ff      <= spg_pkg::RST_PWR_SECOND[0];
    end else if (wr_go && wr_addr_ff == spg_pkg::OFF_PWR_FIRST) begin
      power_reduction_first_ff <= wbyte;
    end else if (wr_go && wr_addr_ff == spg_pkg::OFF_PWR_SECOND) begin
      gate_timer_three_ff      <= wbyte[spg_pkg::GATE_TIMER3_BIT];    // [R25]
    end
  end

  // Timed unlock: a write with both bits one opens a four-cycle window in which
  // a write of off=1, unlock=0 sets the off bit. A plain write cannot set it.
  logic misc_wr;
  assign misc_wr = wr_go && wr_addr_ff == spg_pkg::OFF_CORE_MISC;
  logic unlock_req;
  logic set_req;
  assign unlock_req = misc_wr && wbyte[spg_pkg::BO_OFF_BIT] && wbyte[spg_pkg::BO_UNLOCK_BIT];
  assign set_req    = misc_wr && wbyte[spg_pkg::BO_OFF_BIT] && !wbyte[spg_pkg::BO_UNLOCK_BIT]
                      && brownout_sleep_unlock_ff;                     // [R9]

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      brownout_sleep_unlock_ff <= spg_pkg::RST_CORE_MISC[spg_pkg::BO_UNLOCK_BIT];
      unlock_cnt_ff            <= 3'h0;
    end else if (unlock_req) begin
      brownout_sleep_unlock_ff <= 1'b1;                                // [R5]
      unlock_cnt_ff            <= spg_pkg::UNLOCK_WINDOW_CYC;
    end else if (set_req || unlock_cnt_ff == 3'h1) begin
      brownout_sleep_unlock_ff <= 1'b0;                                // [R5]
      unlock_cnt_ff            <= 3'h0;
    end else if (unlock_cnt_ff != 3'h0) begin
      unlock_cnt_ff            <= unlock_cnt_ff - 3'h1;
    end
  end

  // Once set, the off bit counts three cycles to become active, stays active for
  // three more, then clears itself with no software write.
  logic bo_active;
  assign bo_active = brownout_sleep_off_ff && (bo_arm_cnt_ff == 2'h0);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      brownout_sleep_off_ff <= spg_pkg::RST_CORE_MISC[spg_pkg::BO_OFF_BIT];
      bo_arm_cnt_ff         <= 2'h0;
      bo_life_cnt_ff        <= 2'h0;
    end else if (set_req) begin
      brownout_sleep_off_ff <= 1'b1;                                   // [R5]
      bo_arm_cnt_ff         <= spg_pkg::BO_OFF_LIFE_CYC;               // [R6]
      bo_life_cnt_ff        <= spg_pkg::BO_OFF_LIFE_CYC;
    end else if (bo_arm_cnt_ff != 2'h0) begin
      bo_arm_cnt_ff         <= bo_arm_cnt_ff - 2'h1;                   // [R6]
    end else if (bo_life_cnt_ff != 2'h0) begin
      bo_life_cnt_ff        <= bo_life_cnt_ff - 2'h1;
      brownout_sleep_off_ff <= (bo_life_cnt_ff != 2'h1);               // [R7]
    end
  end

  // Sleep sequencer.
  spg_pkg::spg_state_t state_ff;
  logic [2:0]          wake_cnt_ff;
  logic                bo_off_latch_ff;
  logic [2:0]          mode_sel;
  logic                mode_ok;
  assign mode_sel = sleep_mode_control_ff[3:1];
  assign mode_ok  = mode_sel != spg_pkg::MODE_RSVD_A &&
                    mode_sel != spg_pkg::MODE_RSVD_B;                  // [R24]

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff        <= spg_pkg::ST_RUN;
      sleep_mode_out  <= 3'h0;
      bo_off_latch_ff <= 1'b0;
      wake_cnt_ff     <= 3'h0;
    end else begin
      case (state_ff)
        spg_pkg::ST_RUN: begin
          if (sleep_instr && sleep_mode_control_ff[spg_pkg::SLEEP_ARM_BIT] && mode_ok) begin
            state_ff        <= spg_pkg::ST_SLEEP;                      // [R2]
            sleep_mode_out  <= mode_sel;                               // [R1]
            bo_off_latch_ff <= bo_active;                              // [R8]
          end
        end
        spg_pkg::ST_SLEEP: begin
          if (wake_event) begin
            bo_off_latch_ff <= 1'b0;
            if (sleep_mode_out == spg_pkg::MODE_STANDBY ||
                sleep_mode_out == spg_pkg::MODE_EXT_STBY) begin
              state_ff    <= spg_pkg::ST_WAKE;                         // [R23]
              wake_cnt_ff <= spg_pkg::STANDBY_WAKE_CYC - 3'h1;
            end else begin
              state_ff    <= spg_pkg::ST_RUN;
            end
          end
        end
        spg_pkg::ST_WAKE: begin
          if (wake_cnt_ff == 3'h1) begin
            state_ff <= spg_pkg::ST_RUN;                               // [R23]
          end
          wake_cnt_ff <= wake_cnt_ff - 3'h1;
        end
        default: state_ff <= spg_pkg::ST_RUN;
      endcase
    end
  end

  assign sleep_active          = state_ff == spg_pkg::ST_SLEEP;
  assign core_halt             = state_ff != spg_pkg::ST_RUN;
  assign brownout_detector_off = bo_off_latch_ff;

  // Clock enables: a gated module keeps its flops, so clearing the bit resumes it
  // exactly where it stopped. Register access is refused by the peripheral bus.
  assign clk_en_two_wire    = !power_reduction_first_ff[spg_pkg::GATE_TWO_WIRE_BIT]; // [R11] [R21]
  assign clk_en_timer_two   = !(power_reduction_first_ff[spg_pkg::GATE_TIMER2_BIT]
                               && !timer_two_async_select);                          // [R12]
  assign clk_en_timer_zero  = !power_reduction_first_ff[spg_pkg::GATE_TIMER0_BIT];   // [R13] [R22]
  assign clk_en_serial_one  = !power_reduction_first_ff[spg_pkg::GATE_SERIAL1_BIT];  // [R14]
  assign clk_en_timer_one   = !power_reduction_first_ff[spg_pkg::GATE_TIMER1_BIT];   // [R15]
  assign clk_en_spi         = !power_reduction_first_ff[spg_pkg::GATE_SPI_BIT];      // [R16]
  assign clk_en_serial_zero = !power_reduction_first_ff[spg_pkg::GATE_SERIAL0_BIT];  // [R17]
  assign clk_en_adc         = !power_reduction_first_ff[spg_pkg::GATE_ADC_BIT];      // [R18]
  assign clk_en_timer_three = !gate_timer_three_ff;                                  // [R10]
  assign comparator_mux_allow = clk_en_adc;                                          // [R19]

  // Read channel: one-cycle latency, unmapped addresses give SLVERR and zero.
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= spg_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= addr_mapped(s_axi_araddr) ? spg_pkg::RESP_OKAY : spg_pkg::RESP_SLVERR;
      s_axi_rdata  <= 32'h0;
      if (addr_mapped(s_axi_araddr)) begin
        if (s_axi_araddr[4]) begin
          s_axi_rdata <= {24'h0, 2'h0, bo_active, bo_off_latch_ff, sleep_mode_out,
                          core_halt};
        end else begin
          case (s_axi_araddr[3:0])
            spg_pkg::OFF_SLEEP_CTRL: s_axi_rdata <= {24'h0, sleep_mode_control_ff};
            spg_pkg::OFF_CORE_MISC:  s_axi_rdata <= {24'h0, 1'b0, brownout_sleep_off_ff,
                                                     brownout_sleep_unlock_ff, 5'h0};
            spg_pkg::OFF_PWR_SECOND: s_axi_rdata <= {24'h0, 7'h0, gate_timer_three_ff}; // [R25]
            default:                 s_axi_rdata <= {24'h0, power_reduction_first_ff};
          endcase
        end
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : spg_ctrl

/* testbench/spg_ctrl_sva.sv */
`timescale 1ns/1ps
// Ties sleep, wake and gating outputs to their causes.
module spg_ctrl_sva (
  input wire logic       clock,                  // Clock.
  input wire logic       reset_n,                // Reset, active low.
  input wire logic       sleep_instr,            // Sleep pulse.
  input wire logic       wake_event,             // Wake pulse.
  input wire logic       timer_two_async_select, // Timer two async.
  input wire logic       core_halt,              // Core stalled.
  input wire logic       sleep_active,           // Asleep.
  input wire logic [2:0] sleep_mode_out,         // Latched mode.
  input wire logic       brownout_detector_off,  // Detector off.
  input wire logic       clk_en_timer_two,       // Timer two clock.
  input wire logic       clk_en_adc,             // ADC clock.
  input wire logic       comparator_mux_allow    // Mux allowed.
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  // Sleep is entered only from an executed sleep instruction.
  a_sleep_from_instr: assert property ($rose(sleep_active) |-> $past(sleep_instr))
    else $error("sleep entered without instruction");
  a_no_rsvd_mode: assert property ($rose(sleep_active) |-> !sleep_mode_out[2] || sleep_mode_out[1])
    else $error("reserved mode entered");
  a_halt_in_sleep: assert property (sleep_active |-> core_halt)
    else $error("core runs while asleep");
  a_detector_in_sleep: assert property (brownout_detector_off |-> core_halt)
    else $error("detector off outside sleep");
  a_adc_mux_block: assert property (!clk_en_adc |-> !comparator_mux_allow)
    else $error("mux allowed while adc gated");
  a_async_timer_two: assert property (timer_two_async_select |-> clk_en_timer_two)
    else $error("async timer two gated");
  // Standby keeps the oscillator, so the stall after wake is short but fixed.
  a_standby_wake: assert property (sleep_active && wake_event && sleep_mode_out[2:1] == 2'h3
    |=> core_halt [*5] ##[1:2] !core_halt)
    else $error("standby wake length wrong");
  a_plain_wake: assert property (sleep_active && wake_event && sleep_mode_out[2:1] != 2'h3
    |=> !sleep_active)
    else $error("wake not taken");

  c_standby: cover property ($rose(sleep_active) && sleep_mode_out == 3'h7);
  c_detector: cover property ($rose(brownout_detector_off));
  c_adc_gated: cover property ($fell(clk_en_adc));
endmodule : spg_ctrl_sva

/* testbench/spg_core_model.sv */
`timescale 1ns/1ps
// Core side: issues sleep only while running, and one-cycle wake pulses.
module spg_core_model (
  input wire logic clock,       // Clock.
  input wire logic reset_n,     // Reset, active low.
  input wire logic sleep_req,   // Bench asks for a sleep.
  input wire logic wake_req,    // Bench asks for a wake.
  input wire logic core_halt,   // Core stalled.
  output logic     sleep_instr, // Sleep executed.
  output logic     wake_event   // Wake condition.
);
  // A halted core executes nothing, so sleep never issues while stalled.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sleep_instr <= 1'h0;
      wake_event  <= 1'h0;
    end else begin
      sleep_instr <= sleep_req && !core_halt && !sleep_instr;
      wake_event  <= wake_req && !wake_event;
    end
  end
endmodule : spg_core_model

/* testbench/sleep_and_power_gating_control_tb.sv */
`timescale 1ns/1ps
module sleep_and_power_gating_control_tb;
  logic        clock = 1'h0;
  logic        reset_n = 1'h0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, seed = 32'h8AF32AB1, d, v;
  logic        awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, async_sel = 1'h0;
  logic        sleep_req = 1'h0, wake_req = 1'h0;
  logic [1:0]  r;
  wire logic   awready, wready, bvalid, arready, rvalid, sleep_instr, wake_event;
  wire logic   core_halt, sleep_active, bdo, mux;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [2:0]  mode_out;
  wire logic [8:0]  en;
  int          mismatches = 0, check_count = 0, cyc = 0;

  spg_ctrl u_dut (.clock(clock), .reset_n(reset_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'h1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'h1),
    .sleep_instr(sleep_instr), .wake_event(wake_event), .timer_two_async_select(async_sel),
    .core_halt(core_halt), .sleep_active(sleep_active), .sleep_mode_out(mode_out),
    .brownout_detector_off(bdo), .clk_en_two_wire(en[8]), .clk_en_timer_two(en[7]),
    .clk_en_timer_zero(en[6]), .clk_en_serial_one(en[5]), .clk_en_timer_one(en[4]),
    .clk_en_spi(en[3]), .clk_en_serial_zero(en[2]), .clk_en_adc(en[1]),
    .clk_en_timer_three(en[0]), .comparator_mux_allow(mux));

  spg_core_model u_core (.clock(clock), .reset_n(reset_n), .sleep_req(sleep_req),
    .wake_req(wake_req), .core_halt(core_halt), .sleep_instr(sleep_instr),
    .wake_event(wake_event));

  always #5 clock = ~clock;

  // A hang anywhere ends in the same report.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Clock enables are the inverted gate bits; async timer two is never gated.
  function automatic logic [9:0] exp_en(input logic [7:0] p0, input logic p1, input logic as);
    return {~p0[7], ~p0[6] | as, ~p0[5:0], ~p1, ~p0[0]};
  endfunction : exp_en

  task automatic results();
    if (mismatches == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Both halves offered together, each dropped when taken; response ends it.
  task automatic wr(input logic [31:0] a, input logic [31:0] dat);
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!bvalid);
    r = bresp;
  endtask : wr

  task automatic rd(input logic [31:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask : rd

  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    rd(a);
    chk("register", e, d);
  endtask : rdc

  task automatic do_reset();
    reset_n <= 1'h0;
    repeat (6) @(posedge clock);
    reset_n <= 1'h1;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 4; i++) rdc(i * 4, 32'h0);
    chk("clk_en", 10'h3FF, {en, mux});
  endtask : do_reset

  task automatic pulse(input logic slp);
    if (slp) sleep_req <= 1'h1;
    else wake_req <= 1'h1;
    @(posedge clock);
    sleep_req <= 1'h0;
    wake_req <= 1'h0;
    repeat (slp ? 3 : 10) @(posedge clock);
  endtask : pulse

  // Timed unlock, then sleep a set number of cycles after the final write.
  task automatic brownout_detector(input logic unl, input int dly, input logic e);
    wr(0, 32'h5);
    if (unl) wr(4, 32'h60);
    wr(4, 32'h40);
    repeat (dly) @(posedge clock);
    pulse(1'h1);
    chk("detector_off", e, bdo);
    pulse(1'h0);
    wr(0, 32'h0);
    rdc(4, 32'h0);
  endtask : brownout_detector

  initial begin
    do_reset();
    wr(0, 32'h4);
    pulse(1'h1);
    chk("sleep_active", 1'h0, sleep_active);
    for (int m = 0; m < 8; m++) begin
      wr(0, {28'h0, m[2:0], 1'h1});
      pulse(1'h1);
      chk("sleep_active", m != 4 && m != 5, sleep_active);
      if (m != 4 && m != 5) chk("mode", m, mode_out);
      rdc(0, {m[2:0], 1'h1});
      if (m != 4 && m != 5) rdc(32'h10, {m[2:0], 1'h1});
      pulse(1'h0);
      chk("core_halt", 1'h0, core_halt);
      wr(0, 32'h0);
    end
    brownout_detector(1'h1, 1, 1'h1);
    brownout_detector(1'h0, 1, 1'h0);
    brownout_detector(1'h1, 12, 1'h0);
    rd(32'h14);
    chk("rresp", 2'h2, r);
    chk("rdata", 32'h0, d);
    wr(32'h10, 32'h1);
    chk("bresp", 2'h2, r);
    for (int i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      v = (i == 0) ? 32'hFFFF_FFFF : seed;
      async_sel <= v[9];
      wr(32'hC, v);
      wr(8, v >> 8);
      rdc(32'hC, v[7:0]);
      rdc(8, v[8]);
      chk("clk_en", exp_en(v[7:0], v[8], v[9]), {en, mux});
    end
    do_reset();
    results();
  end
endmodule : sleep_and_power_gating_control_tb

bind spg_ctrl spg_ctrl_sva u_sva (.clock(clock), .reset_n(reset_n), .sleep_instr(sleep_instr),
  .wake_event(wake_event), .timer_two_async_select(timer_two_async_select),
  .core_halt(core_halt), .sleep_active(sleep_active), .sleep_mode_out(sleep_mode_out),
  .brownout_detector_off(brownout_detector_off), .clk_en_timer_two(clk_en_timer_two),
  .clk_en_adc(clk_en_adc), .comparator_mux_allow(comparator_mux_allow));
